// file: rtl/omcs_pkg.sv
// Shared constants and state types of the optical module control link
`default_nettype none
package omcs_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int T_RESET_US = 10;
  localparam int T_BUF_US = 20;
  localparam int T_GAP_MS = 10;
  localparam int T_DATA_MS = 1000;
  localparam int F_SCL_HZ = 100_000;
  localparam int TRST_CYC = (T_RESET_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int TBUF_CYC = (T_BUF_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int GAP_CYC_DEF = T_GAP_MS * (CLK_HZ / 1000);
  localparam int DRDY_CYC_DEF = T_DATA_MS * (CLK_HZ / 1000);
  localparam int QTR_CYC = (CLK_HZ + 4 * F_SCL_HZ - 1) / (4 * F_SCL_HZ);
  // ==========================================================
  // Two-wire addresses and the control/status byte
  localparam logic [6:0] IDENT_PAGE_ADDRESS = 7'h50;
  localparam logic [6:0] DIAG_PAGE_ADDRESS = 7'h51;
  localparam logic [7:0] CSB_OFF = 8'h6e;
  localparam logic [7:0] CSB_RST = 8'h01;
  localparam int CSB_TXD = 7;
  localparam int CSB_SOFT = 6;
  localparam int CSB_FAULT = 2;
  localparam int CSB_LOS = 1;
  localparam int CSB_NRDY = 0;
  // ==========================================================
  // Controller APB registers
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_CMD = 12'h004;
  localparam logic [11:0] REG_STAT = 12'h008;
  localparam int CTRL_TXD = 0;
  localparam int CMD_WD_LSB = 0;
  localparam int CMD_OFF_LSB = 8;
  localparam int CMD_PAGE = 16;
  localparam int CMD_RNW = 17;
  localparam int CMD_NB_LSB = 18;
  localparam int ST_BUSY = 0;
  localparam int ST_NACK = 1;
  localparam int ST_FAULT = 2;
  localparam int ST_LOS = 3;
  localparam int ST_TXD = 4;
  localparam int ST_RD_LSB = 8;
  // ==========================================================
  // State types
  typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_RACK} omcs_dst_t;
  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_BUF} omcs_hst_t;
endpackage
`default_nettype wire

// file: rtl/omcs_if.sv
// Pin bundle between the module end and the host controller end
`default_nettype none
interface omcs_if;
  logic tx_disable;
  logic tx_fault;
  logic rx_los;
  logic h_scl_o, h_scl_oe, h_sda_o, h_sda_oe;
  logic d_scl_o, d_scl_oe, d_sda_o, d_sda_oe;
  logic scl;
  logic sda;
  // ==========================================================
  // Open-drain wired-AND with pull-ups
  assign scl = !(h_scl_oe && !h_scl_o) && !(d_scl_oe && !d_scl_o);
  assign sda = !(h_sda_oe && !h_sda_o) && !(d_sda_oe && !d_sda_o);
  modport dev (input tx_disable, scl, sda,
               output tx_fault, rx_los, d_scl_o, d_scl_oe, d_sda_o, d_sda_oe);
  modport host (output tx_disable, h_scl_o, h_scl_oe, h_sda_o, h_sda_oe,
                input tx_fault, rx_los, scl, sda);
endinterface
`default_nettype wire

// file: rtl/omcs_sync.sv
// Two-flop synchroniser for inputs from outside the pclk domain
`default_nettype none
module omcs_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
  assign q = q_ff;
endmodule
`default_nettype wire

// file: rtl/omcs_device.sv
// Module end: laser control, fault latch, loss of signal, two-wire slave
//
// Local design decision: the APB register port.
`default_nettype none
module omcs_device
  import omcs_pkg::*;
#(
  parameter int DRDY_CYC = DRDY_CYC_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  omcs_if.dev link,
  input wire logic fault_det,
  input wire logic sig_lost,
  output logic laser_on,
  output logic soft_off
);
  localparam int HW = $clog2(TRST_CYC + 1);
  localparam int DW = $clog2(DRDY_CYC + 1);

  // ==========================================================
  // Input synchronisers and edge detection
  logic [4:0] sync_w;
  logic txd_s, scl_s, sda_s, fault_s, lost_s;
  logic txd_p_ff, scl_p_ff, sda_p_ff;
  logic scl_rise, scl_fall, start_c, stop_c, txd_fall;

  omcs_sync #(.W(5)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({link.tx_disable, link.scl, link.sda, fault_det, sig_lost}),
    .q(sync_w)
  );
  assign {txd_s, scl_s, sda_s, fault_s, lost_s} = sync_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_p_ff <= 1'b0;
      scl_p_ff <= 1'b0;
      sda_p_ff <= 1'b0;
    end else begin
      txd_p_ff <= txd_s;
      scl_p_ff <= scl_s;
      sda_p_ff <= sda_s;
    end
  end
  assign scl_rise = scl_s && !scl_p_ff;
  assign scl_fall = !scl_s && scl_p_ff;
  assign start_c = scl_s && scl_p_ff && !sda_s && sda_p_ff;
  assign stop_c = scl_s && scl_p_ff && sda_s && !sda_p_ff;
  assign txd_fall = !txd_s && txd_p_ff;

  // ==========================================================
  // Fault latch and laser drive
  logic [HW-1:0] hold_ff;
  logic fault_ff, laser_ff, los_ff, soft_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff <= '0;
    end else if (!txd_s) begin
      hold_ff <= '0;
    end else if (hold_ff != HW'(TRST_CYC)) begin
      hold_ff <= hold_ff + 1'b1;
    end
  end

  // Set wins over the release-clear, so a persisting fault re-latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_ff <= 1'b0;
    end else if (fault_s && laser_ff) begin
      fault_ff <= 1'b1;
    end else if (txd_fall && hold_ff == HW'(TRST_CYC)) begin
      fault_ff <= 1'b0;
    end
  end

  // Laser is off in reset and enabled on the first clock after release; nothing needs warming up here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      laser_ff <= 1'b0;
    end else begin
      laser_ff <= !txd_s && !soft_ff && !fault_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      los_ff <= 1'b0;
    end else begin
      los_ff <= lost_s;
    end
  end

  // ==========================================================
  // Data-ready timer
  logic [DW-1:0] drdy_cnt_ff;
  logic nrdy_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drdy_cnt_ff <= '0;
      nrdy_ff <= 1'b1;
    end else if (drdy_cnt_ff == DW'(DRDY_CYC - 1)) begin
      nrdy_ff <= 1'b0;
    end else begin
      drdy_cnt_ff <= drdy_cnt_ff + 1'b1;
    end
  end

  // ==========================================================
  // Control/status byte
  logic [7:0] csb;
  always_comb begin
    csb = CSB_RST & 8'h00;
    csb[CSB_TXD] = txd_s;
    csb[CSB_SOFT] = soft_ff;
    csb[CSB_FAULT] = fault_ff;
    csb[CSB_LOS] = los_ff;
    csb[CSB_NRDY] = nrdy_ff;
  end

  // ==========================================================
  // Two-wire slave
  omcs_dst_t st_ff;
  logic [3:0] bit_ff;
  logic [7:0] sh_ff, tx_ff, ptr_ff, rd_byte;
  logic first_ff, offp_ff, rnw_ff, page_ff, ack_ff, wr_stb;

  assign rd_byte = (page_ff && ptr_ff == CSB_OFF) ? csb : 8'h00;
  assign wr_stb = st_ff == D_RX && scl_fall && bit_ff == 4'h8 && !first_ff && !offp_ff;

  // Slave is ready from reset release and never stretches the clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= D_IDLE;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      tx_ff <= 8'h00;
      ptr_ff <= 8'h00;
      first_ff <= 1'b0;
      offp_ff <= 1'b0;
      rnw_ff <= 1'b0;
      page_ff <= 1'b0;
      ack_ff <= 1'b0;
    end else if (start_c) begin
      st_ff <= D_RX;
      bit_ff <= 4'h0;
      first_ff <= 1'b1;
    end else if (stop_c) begin
      st_ff <= D_IDLE;
    end else begin
      unique case (st_ff)
        D_IDLE: begin
        end
        D_RX: begin
          if (scl_rise && bit_ff != 4'h8) begin
            sh_ff <= {sh_ff[6:0], sda_s};
            bit_ff <= bit_ff + 4'h1;
          end else if (scl_fall && bit_ff == 4'h8) begin
            first_ff <= 1'b0;
            offp_ff <= 1'b0;
            if (first_ff) begin
              if (sh_ff[7:1] == IDENT_PAGE_ADDRESS || sh_ff[7:1] == DIAG_PAGE_ADDRESS) begin
                st_ff <= D_ACK;
                page_ff <= sh_ff[7:1] == DIAG_PAGE_ADDRESS;
                rnw_ff <= sh_ff[0];
                offp_ff <= !sh_ff[0];
              end else begin
                st_ff <= D_IDLE;
              end
            end else begin
              st_ff <= D_ACK;
              ptr_ff <= offp_ff ? sh_ff : ptr_ff + 8'h01;
            end
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            bit_ff <= 4'h0;
            if (rnw_ff) begin
              st_ff <= D_TX;
              tx_ff <= rd_byte;
              ptr_ff <= ptr_ff + 8'h01;
            end else begin
              st_ff <= D_RX;
            end
          end
        end
        D_TX: begin
          if (scl_fall) begin
            tx_ff <= {tx_ff[6:0], 1'b0};
            bit_ff <= bit_ff + 4'h1;
            if (bit_ff == 4'h7) begin
              st_ff <= D_RACK;
            end
          end
        end
        D_RACK: begin
          if (scl_rise) begin
            ack_ff <= !sda_s;
          end else if (scl_fall) begin
            if (ack_ff) begin
              st_ff <= D_TX;
              bit_ff <= 4'h0;
              tx_ff <= rd_byte;
              ptr_ff <= ptr_ff + 8'h01;
            end else begin
              st_ff <= D_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Write lands on the data byte itself, well inside any write budget
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_ff <= 1'b0;
    end else if (wr_stb && page_ff && ptr_ff == CSB_OFF) begin
      soft_ff <= sh_ff[CSB_SOFT];
    end
  end

  // ==========================================================
  // Outputs
  assign link.tx_fault = fault_ff;
  assign link.rx_los = los_ff;
  assign link.d_scl_o = 1'b0;
  assign link.d_scl_oe = 1'b0;
  assign link.d_sda_o = 1'b0;
  assign link.d_sda_oe = st_ff == D_ACK || (st_ff == D_TX && !tx_ff[7]);
  assign laser_on = laser_ff;
  assign soft_off = soft_ff;
endmodule
`default_nettype wire

// file: rtl/omcs_host.sv
// Host end: APB-programmed two-wire master and disable pin pacing
`default_nettype none
module omcs_host
  import omcs_pkg::*;
#(
  parameter int GAP_CYC = GAP_CYC_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  omcs_if.host link
);
  localparam int GW = $clog2(GAP_CYC + 1);

  // ==========================================================
  // Pin synchronisers
  logic [3:0] sync_w;
  logic scl_s, sda_s, fault_s, los_s;
  omcs_sync #(.W(4)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({link.scl, link.sda, link.tx_fault, link.rx_los}),
    .q(sync_w)
  );
  assign {scl_s, sda_s, fault_s, los_s} = sync_w;

  // ==========================================================
  // APB slave, zero wait states
  logic acc, wr, mapped, go;
  logic req_ff, page_ff, rnw_ff, nack_ff;
  logic [7:0] off_ff, wd_ff, rd_ff;
  logic [1:0] nb_ff;
  logic [31:0] prdata_ff, stat;
  omcs_hst_t st_ff;
  logic txd_ff;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign mapped = paddr == REG_CTRL || paddr == REG_CMD || paddr == REG_STAT;
  assign go = wr && paddr == REG_CMD && st_ff == H_IDLE;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = prdata_ff;

  always_comb begin
    stat = 32'h0000_0000;
    stat[ST_BUSY] = st_ff != H_IDLE;
    stat[ST_NACK] = nack_ff;
    stat[ST_FAULT] = fault_s;
    stat[ST_LOS] = los_s;
    stat[ST_TXD] = txd_ff;
    stat[ST_RD_LSB +: 8] = rd_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        REG_CTRL: prdata_ff <= {31'h0000_0000, req_ff};
        REG_CMD: prdata_ff <= {12'h000, nb_ff, rnw_ff, page_ff, off_ff, wd_ff};
        REG_STAT: prdata_ff <= stat;
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_ff <= 1'b0;
      page_ff <= 1'b0;
      rnw_ff <= 1'b0;
      off_ff <= 8'h00;
      wd_ff <= 8'h00;
      nb_ff <= 2'h0;
    end else if (wr && paddr == REG_CTRL) begin
      req_ff <= pwdata[CTRL_TXD];
    end else if (go) begin
      wd_ff <= pwdata[CMD_WD_LSB +: 8];
      off_ff <= pwdata[CMD_OFF_LSB +: 8];
      page_ff <= pwdata[CMD_PAGE];
      rnw_ff <= pwdata[CMD_RNW];
      nb_ff <= pwdata[CMD_NB_LSB +: 2];
    end
  end

  // ==========================================================
  // Disable pin pacing: request is a level, pin follows when legal
  logic [GW-1:0] gap_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_ff <= 1'b0;
      gap_ff <= '0;
    end else begin
      if (req_ff && !txd_ff && gap_ff == GW'(GAP_CYC)) begin
        txd_ff <= 1'b1;
        gap_ff <= '0;
      end else begin
        if (!req_ff && txd_ff && gap_ff >= GW'(TRST_CYC)) begin
          txd_ff <= 1'b0;
        end
        if (gap_ff != GW'(GAP_CYC)) begin
          gap_ff <= gap_ff + 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Two-wire master: each bit is four quarter periods
  logic [1:0] ph_ff, bidx_ff;
  logic [3:0] bit_ff;
  logic [9:0] q_ff, lim;
  logic [7:0] sh_ff, nxt_byte;
  logic scl_oe_ff, sda_oe_ff, ackb_ff, tick, stall, rx_byte;

  assign lim = st_ff == H_BUF ? 10'(TBUF_CYC - 1) : 10'(QTR_CYC - 1);
  assign stall = st_ff == H_BIT && ph_ff == 2'h2 && !scl_s;
  assign tick = q_ff == lim && !stall;
  assign rx_byte = rnw_ff && bidx_ff != 2'h0;
  assign nxt_byte = rnw_ff ? 8'hff : (bidx_ff == 2'h0 ? off_ff : wd_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= 10'h000;
    end else if (st_ff == H_IDLE || stall || tick) begin
      q_ff <= 10'h000;
    end else begin
      q_ff <= q_ff + 10'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= H_IDLE;
      ph_ff <= 2'h0;
      bit_ff <= 4'h0;
      bidx_ff <= 2'h0;
      sh_ff <= 8'h00;
      rd_ff <= 8'h00;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      ackb_ff <= 1'b0;
      nack_ff <= 1'b0;
    end else if (go) begin
      st_ff <= H_START;
      ph_ff <= 2'h0;
      nack_ff <= 1'b0;
    end else if (tick) begin
      ph_ff <= ph_ff + 2'h1;
      unique case (st_ff)
        H_IDLE: begin
        end
        H_START: begin
          if (ph_ff == 2'h0) sda_oe_ff <= 1'b1;
          if (ph_ff == 2'h1) scl_oe_ff <= 1'b1;
          if (ph_ff == 2'h2) begin
            st_ff <= H_BIT;
            ph_ff <= 2'h0;
            bit_ff <= 4'h0;
            bidx_ff <= 2'h0;
            sh_ff <= {page_ff ? DIAG_PAGE_ADDRESS : IDENT_PAGE_ADDRESS, rnw_ff};
          end
        end
        H_BIT: begin
          unique case (ph_ff)
            2'h0: sda_oe_ff <= bit_ff != 4'h8 && !sh_ff[7] && !rx_byte;
            2'h1: scl_oe_ff <= 1'b0;
            2'h2: begin
              if (bit_ff == 4'h8) ackb_ff <= sda_s;
              else sh_ff <= {sh_ff[6:0], sda_s};
            end
            2'h3: begin
              scl_oe_ff <= 1'b1;
              bit_ff <= bit_ff + 4'h1;
              if (bit_ff == 4'h8) begin
                bit_ff <= 4'h0;
                if (rx_byte) rd_ff <= sh_ff;
                if (!rx_byte && ackb_ff) begin
                  nack_ff <= 1'b1;
                  st_ff <= H_STOP;
                end else if (2'(bidx_ff + 2'h1) >= nb_ff) begin
                  st_ff <= H_STOP;
                end else begin
                  bidx_ff <= bidx_ff + 2'h1;
                  sh_ff <= nxt_byte;
                end
              end
            end
          endcase
        end
        H_STOP: begin
          if (ph_ff == 2'h0) sda_oe_ff <= 1'b1;
          if (ph_ff == 2'h1) scl_oe_ff <= 1'b0;
          if (ph_ff == 2'h2) sda_oe_ff <= 1'b0;
          if (ph_ff == 2'h3) st_ff <= H_BUF;
        end
        H_BUF: begin
          st_ff <= H_IDLE;
          ph_ff <= 2'h0;
        end
      endcase
    end
  end

  // ==========================================================
  // Pins
  assign link.tx_disable = txd_ff;
  assign link.h_scl_o = 1'b0;
  assign link.h_scl_oe = scl_oe_ff;
  assign link.h_sda_o = 1'b0;
  assign link.h_sda_oe = sda_oe_ff;
endmodule
`default_nettype wire

// file: sim/omcs_link_asserts.sv
// Timing and protocol checks on the pin bundle between the two ends
`default_nettype none
module omcs_link_asserts
  import omcs_pkg::*;
#(
  parameter int GAP_CYC = GAP_CYC_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_disable,
  input wire logic tx_fault,
  input wire logic rx_los,
  input wire logic d_scl_oe,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // 400 kHz at 25 MHz is 62.5 cycles per clock period
  localparam int MIN_PER = 62;
  int gap_ff, hi_ff, lo_ff, free_ff, per_ff;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_ff <= 0;
    else if ($rose(tx_disable)) gap_ff <= 1;
    else if (gap_ff < GAP_CYC) gap_ff <= gap_ff + 1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hi_ff <= 0;
    else if (!tx_disable) hi_ff <= 0;
    else if (hi_ff < TRST_CYC) hi_ff <= hi_ff + 1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lo_ff <= 255;
    else if (tx_disable) lo_ff <= 0;
    else if (lo_ff < 255) lo_ff <= lo_ff + 1;
  end
  // Starts saturated so a start right after reset is legal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) free_ff <= TBUF_CYC;
    else if (!(scl && sda)) free_ff <= 0;
    else if (free_ff < TBUF_CYC) free_ff <= free_ff + 1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) per_ff <= MIN_PER;
    else if ($rose(scl)) per_ff <= 1;
    else if (per_ff < MIN_PER) per_ff <= per_ff + 1;
  end
  // ==========================================================
  // Properties
  property p_gap; $rose(tx_disable) |-> gap_ff >= GAP_CYC - 1; endproperty
  property p_hold; $fell(tx_disable) |-> hi_ff >= TRST_CYC; endproperty
  property p_keep; tx_fault && tx_disable |=> tx_fault; endproperty
  property p_clr; $fell(tx_fault) |-> !tx_disable && lo_ff <= 8; endproperty
  property p_buf; $fell(sda) && scl |-> free_ff >= TBUF_CYC - 1; endproperty
  property p_stop; $rose(sda) && scl |=> (scl && sda) [*8]; endproperty
  property p_rate; $rose(scl) |-> per_ff >= MIN_PER; endproperty
  property p_nostretch; !d_scl_oe; endproperty
  property p_dsda; $changed(d_sda_oe) |-> !scl; endproperty
  a_gap: assert property (p_gap)
    else $error("disable request raised again too soon");
  a_hold: assert property (p_hold)
    else $error("disable request released too early");
  a_keep: assert property (p_keep)
    else $error("fault dropped while disable held");
  a_clr: assert property (p_clr)
    else $error("fault cleared without disable release");
  a_buf: assert property (p_buf)
    else $error("start too soon after stop");
  a_stop: assert property (p_stop)
    else $error("bus not idle after stop");
  a_rate: assert property (p_rate)
    else $error("serial clock too fast");
  a_nostretch: assert property (p_nostretch)
    else $error("module stretched the clock");
  a_dsda: assert property (p_dsda)
    else $error("module moved data while clock high");
  c_clr: cover property ($fell(tx_fault));
  c_los: cover property ($rose(rx_los));
  c_start: cover property ($fell(sda) && scl);
endmodule
`default_nettype wire

// file: sim/optical_module_ctrl_status_tb_top.sv
// Bench: host controller and module end joined over the pin bundle
`default_nettype none
module optical_module_ctrl_status_tb_top
  import omcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Short counts keep the run small
  localparam int GAP = 600;
  localparam int DRDY = 30000;
  logic pclk = 1'b0;
  // Left unknown so the drop to zero at time 0 is a real reset edge
  logic presetn;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic fault_det = 1'b0;
  logic sig_lost = 1'b0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, laser_on, soft_off;
  int failures = 0;
  int n_compared = 0;
  logic [31:0] rd;
  logic err;
  omcs_if lnk();
  omcs_device #(.DRDY_CYC(DRDY)) omcs_device_i (.pclk(pclk), .presetn(presetn),
    .link(lnk.dev), .fault_det(fault_det), .sig_lost(sig_lost), .laser_on(laser_on),
    .soft_off(soft_off));
  omcs_host #(.GAP_CYC(GAP)) omcs_host_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(lnk.host));
  omcs_link_asserts #(.GAP_CYC(GAP)) omcs_link_asserts_i (.pclk(pclk), .presetn(presetn),
    .tx_disable(lnk.tx_disable), .tx_fault(lnk.tx_fault), .rx_los(lnk.rx_los),
    .d_scl_oe(lnk.d_scl_oe), .d_sda_oe(lnk.d_sda_oe), .scl(lnk.scl), .sda(lnk.sda));
  initial begin
    forever #20 pclk = ~pclk;
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Busy is polled without a count: the watchdog ends a hang
  task automatic tw(input logic pg, input logic rnw, input logic [7:0] off,
                    input logic [7:0] wd, input logic [1:0] nb);
    apb(REG_CMD, 1'b1, {12'h000, nb, rnw, pg, off, wd});
    do apb(REG_STAT, 1'b0, 32'h0); while (rd[ST_BUSY] !== 1'b0);
    chk({31'h0, rd[ST_NACK]}, 32'h0);
  endtask
  task automatic csb(input logic [7:0] exp);
    tw(1'b1, 1'b0, CSB_OFF, 8'h00, 2'h2);
    tw(1'b1, 1'b1, 8'h00, 8'h00, 2'h2);
    chk({24'h0, rd[ST_RD_LSB +: 8]}, {24'h0, exp});
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return laser_on;
      1: return lnk.tx_fault;
      2: return lnk.rx_los;
      default: return lnk.tx_disable;
    endcase
  endfunction
  task automatic waitv(input int s, input logic v, input int maxc);
    for (int i = 0; i < maxc; i++) begin
      @(posedge pclk);
      #1;
      if (pick(s) === v) break;
    end
    chk({31'h0, pick(s)}, {31'h0, v});
  endtask
  task automatic end_sim;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(REG_CTRL, 1'b0, 32'h0); chk(rd, 32'h0);
    apb(REG_STAT, 1'b0, 32'h0); chk(rd & 32'h1f, 32'h0);
    apb(12'h00c, 1'b0, 32'h0); chk({31'h0, err}, 32'h1);
    $display("test reset done");
    tw(1'b0, 1'b0, 8'h00, 8'h00, 2'h2);
    csb(8'h01);
    $display("test pages done");
    tw(1'b1, 1'b0, CSB_OFF, 8'h40, 2'h3);
    waitv(0, 1'b0, 2500);
    chk({31'h0, soft_off}, 32'h1);
    tw(1'b1, 1'b0, CSB_OFF, 8'h00, 2'h3);
    waitv(0, 1'b1, 2500);
    $display("test soft disable done");
    apb(REG_CTRL, 1'b1, 32'h1);
    waitv(3, 1'b1, 50);
    waitv(0, 1'b0, 2500);
    apb(REG_STAT, 1'b0, 32'h0); chk({31'h0, rd[ST_TXD]}, 32'h1);
    apb(REG_CTRL, 1'b1, 32'h0);
    waitv(3, 1'b0, 300);
    waitv(0, 1'b1, 50000);
    // Second request lands inside the spacing window and must wait
    apb(REG_CTRL, 1'b1, 32'h1);
    repeat (100) @(posedge pclk);
    #1 chk({31'h0, lnk.tx_disable}, 32'h0);
    waitv(3, 1'b1, 700);
    apb(REG_CTRL, 1'b1, 32'h0);
    waitv(3, 1'b0, 300);
    waitv(0, 1'b1, 50000);
    $display("test hardware disable done");
    @(posedge pclk);
    fault_det <= 1'b1;
    sig_lost <= 1'b1;
    waitv(1, 1'b1, 25000);
    waitv(2, 1'b1, 2500);
    waitv(0, 1'b0, 50);
    @(posedge pclk);
    fault_det <= 1'b0;
    csb(8'h06);
    @(posedge pclk);
    sig_lost <= 1'b0;
    waitv(2, 1'b0, 2500);
    waitv(1, 1'b1, 1);
    apb(REG_STAT, 1'b0, 32'h0); chk(rd & 32'h1c, 32'h04);
    apb(REG_CTRL, 1'b1, 32'h1);
    waitv(3, 1'b1, 700);
    apb(REG_CTRL, 1'b1, 32'h0);
    waitv(3, 1'b0, 300);
    waitv(1, 1'b0, 20);
    waitv(0, 1'b1, 50000);
    csb(8'h00);
    $display("test fault and loss done");
    end_sim;
  end
  initial begin
    repeat (90000) @(posedge pclk);
    failures++;
    $display("watchdog expired at %0t", $time);
    end_sim;
  end
endmodule
`default_nettype wire
